// *** hdl/psm_consts.svh ***
// constants for the power supply status monitor
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// i2c slave addresses (7 bit)
`define PSM_ADDR_SUPPLY 7'h44
`define PSM_ADDR_FAN 7'h40

// bit positions inside the supply status byte
`define PSM_FAULT_POS 0
`define PSM_PRESENT_POS 3

// bit position of fan fail flags inside the fan status byte
`define PSM_FAN_POS 0

// reset value of the open-drain data driver
`define PSM_SDA_RST 1'b0

// clock rate and timing figures
`define PSM_CLK_KHZ 25000
`define PSM_PG_DELAY_MS 100
`define PSM_PG_LEAD_US 250

`endif

// *** hdl/psm_monitor.sv ***
// power supply status and fault aggregation with i2c status slaves
// Notes on behaviour
// - two rear lamps per supply
// - operating: outputs on, good, both lamps
// - hard faults shut down, lamps off
// - current limit: shut, supply-ok lamp stays
// - disabled, minimal load, general failure encodings
// - any monitored condition raises fault flag
// - fault flags readable at slave 44h
// - presence bits in the same slave
// - front fault lamp on any fault
// - output good only when outputs operating
// - output good drops 250us before outputs when no fault; a fault drops both together
// - output good 100ms after 5.1v good
// - system power good is or of flags
// - system power good shares flag timing
// - one shared enable, also to baseboard
// - channel overload drops shared enable
// - any intrusion switch raises alert
// - fan fails or'd into one alert
// - per-fan fail readable at slave 40h
`timescale 1ns/100ps
`default_nettype none
`include "psm_consts.svh"

module psm_monitor import psm_pkg::*; #(
   parameter int NUM_SUPPLIES = 3,
   parameter int NUM_FANS = 3,
   parameter int NUM_CHANNELS = 4,
   parameter int CNT_W = 22,
   parameter int PG_DELAY_CYC = `PSM_PG_DELAY_MS * `PSM_CLK_KHZ,
   parameter int PG_LEAD_CYC = (`PSM_PG_LEAD_US * `PSM_CLK_KHZ + 999) / 1000
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // baseboard enable request and channel overload sensors
   input wire logic enable_request,
   input wire logic [NUM_CHANNELS-1:0] channel_overload,
   // per-supply sense inputs
   input wire logic [NUM_SUPPLIES-1:0] supply_present,
   input wire logic [NUM_SUPPLIES-1:0] over_voltage,
   input wire logic [NUM_SUPPLIES-1:0] supply_fan_fail,
   input wire logic [NUM_SUPPLIES-1:0] over_temp,
   input wire logic [NUM_SUPPLIES-1:0] neg_short,
   input wire logic [NUM_SUPPLIES-1:0] current_limit,
   input wire logic [NUM_SUPPLIES-1:0] fet_fault,
   input wire logic [NUM_SUPPLIES-1:0] share_fault,
   input wire logic [NUM_SUPPLIES-1:0] rail_5v1_ok,
   input wire logic [NUM_SUPPLIES-1:0] rails_in_reg,
   input wire logic [NUM_SUPPLIES-1:0] rail_drop_warn,
   input wire logic [NUM_SUPPLIES-1:0] minimal_load,
   // chassis sensors
   input wire logic [2:0] intrusion_open,
   input wire logic [NUM_FANS-1:0] fan_locked,
   // per-supply outputs
   output logic [NUM_SUPPLIES-1:0] supply_outputs_on,
   output logic [NUM_SUPPLIES-1:0] supply_fault,
   output logic [NUM_SUPPLIES-1:0] supply_output_good,
   output logic [NUM_SUPPLIES-1:0] supply_ok_lamp,
   output logic [NUM_SUPPLIES-1:0] current_ok_lamp,
   // system outputs
   output logic system_power_good,
   output logic shared_supply_enable,
   output logic front_fault_lamp,
   output logic intrusion_alert,
   output logic fan_fail_alert,
   // i2c pins, open drain
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n
);

   ////////////////////////////////////////////////////////////////////////
   // parameter checks

   // status bytes hold one bit per supply pair field and per fan
   if (NUM_SUPPLIES < 1 || NUM_SUPPLIES > 3 || NUM_FANS < 1 ||
       NUM_FANS > 8 || NUM_CHANNELS < 1 || PG_DELAY_CYC < 1 ||
       PG_LEAD_CYC < 1 || PG_DELAY_CYC >= (1 << CNT_W) ||
       PG_LEAD_CYC >= (1 << CNT_W)) begin : g_bad
      $error("psm_monitor: unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////
   // reset release

   logic [1:0] rst_sync; // release shift chain
   logic rst_n; // synchronous copy of reset

   // two-stage release of the asynchronous reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // shared enable

   logic overload_seen; // latched until request drops

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         overload_seen <= 1'b0;
      end else if (!enable_request) begin
         overload_seen <= 1'b0;
      end else if (|channel_overload) begin
         overload_seen <= 1'b1;
      end
   end

   // one enable line for all supplies
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shared_supply_enable <= 1'b0;
      end else begin
         shared_supply_enable <= enable_request & ~overload_seen &
                                 ~(|channel_overload);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-supply sequencer and status encoding

   logic [NUM_SUPPLIES-1:0] next_fault; // fault flags before the flop
   logic [NUM_SUPPLIES-1:0] next_good; // good flags before the flop

   for (genvar i = 0; i < NUM_SUPPLIES; i++) begin : g_sup
      psm_supply_e st; // sequencer state
      psm_trip_e kind; // latched shutdown class
      psm_trip_e live; // present shutdown class
      logic [CNT_W-1:0] cnt; // delay counter

      always_comb begin
         if (over_voltage[i] | supply_fan_fail[i] | over_temp[i] |
             neg_short[i]) begin
            live = PSM_TRIP_HARD;
         end else if (current_limit[i]) begin
            live = PSM_TRIP_LIMIT;
         end else if (fet_fault[i] | share_fault[i]) begin
            live = PSM_TRIP_GENERAL;
         end else begin
            live = PSM_TRIP_NONE;
         end
      end

      // sequencer: off, ramp, run, drain, tripped
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            st <= PSM_OFF;
            kind <= PSM_TRIP_NONE;
            cnt <= '0;
         end else begin
            case (st)
               PSM_OFF: begin
                  cnt <= '0;
                  kind <= PSM_TRIP_NONE;
                  if (supply_present[i] && live != PSM_TRIP_NONE) begin
                     kind <= live;
                     st <= PSM_TRIP;
                  end else if (supply_present[i] && shared_supply_enable) begin
                     st <= PSM_RAMP;
                  end
               end
               PSM_RAMP: begin
                  if (live != PSM_TRIP_NONE) begin
                     kind <= live;
                     st <= PSM_TRIP;
                  end else if (!shared_supply_enable || !supply_present[i]) begin
                     st <= PSM_OFF;
                  // count from 5.1v reaching its level
                  end else if (rail_5v1_ok[i] && rails_in_reg[i]) begin
                     cnt <= cnt + 1'b1;
                     if (cnt == CNT_W'(PG_DELAY_CYC - 1)) begin
                        cnt <= '0;
                        st <= PSM_RUN;
                     end
                  end else begin
                     cnt <= '0;
                  end
               end
               PSM_RUN: begin
                  cnt <= '0;
                  if (live != PSM_TRIP_NONE) begin
                     kind <= live;
                     st <= PSM_DRAIN;
                  end else if (!shared_supply_enable || rail_drop_warn[i] ||
                               !supply_present[i] || !rails_in_reg[i]) begin
                     st <= PSM_DRAIN;
                  end
               end
               PSM_DRAIN: begin
                  if (kind == PSM_TRIP_NONE && live != PSM_TRIP_NONE) begin
                     kind <= live;
                  end
                  cnt <= cnt + 1'b1;
                  // hold outputs for the lead time
                  if (cnt == CNT_W'(PG_LEAD_CYC - 1)) begin
                     cnt <= '0;
                     st <= (kind != PSM_TRIP_NONE ||
                            live != PSM_TRIP_NONE) ? PSM_TRIP : PSM_OFF;
                  end
               end
               PSM_TRIP: begin
                  // latched off until the supply is pulled
                  cnt <= '0;
                  if (!supply_present[i]) begin
                     st <= PSM_OFF;
                  end
               end
               default: begin
                  st <= PSM_OFF;
               end
            endcase
         end
      end

      assign next_good[i] = (st == PSM_RUN) && live == PSM_TRIP_NONE &&
                            shared_supply_enable && !rail_drop_warn[i] &&
                            supply_present[i] && rails_in_reg[i];
      assign next_fault[i] = supply_present[i] &&
                             (live != PSM_TRIP_NONE || kind != PSM_TRIP_NONE);

      // rear lamps, output and flag encoding
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            supply_outputs_on[i] <= 1'b0;
            supply_fault[i] <= 1'b0;
            supply_output_good[i] <= 1'b0;
            supply_ok_lamp[i] <= 1'b0;
            current_ok_lamp[i] <= 1'b0;
         end else begin
            // good flag from settled run state
            supply_output_good[i] <= next_good[i];
            supply_fault[i] <= next_fault[i];
            // a latched trip keeps outputs off
            supply_outputs_on[i] <= (st == PSM_RAMP || st == PSM_RUN ||
                                     st == PSM_DRAIN) &&
                                    live == PSM_TRIP_NONE &&
                                    kind == PSM_TRIP_NONE;
            if (!supply_present[i]) begin
               // absent supply shows nothing
               supply_ok_lamp[i] <= 1'b0;
               current_ok_lamp[i] <= 1'b0;
            end else if (kind == PSM_TRIP_HARD || live == PSM_TRIP_HARD) begin
               supply_ok_lamp[i] <= 1'b0;
               current_ok_lamp[i] <= 1'b0;
            end else if (kind == PSM_TRIP_LIMIT ||
                         live == PSM_TRIP_LIMIT) begin
               supply_ok_lamp[i] <= 1'b1;
               current_ok_lamp[i] <= 1'b0;
            end else if (kind == PSM_TRIP_GENERAL ||
                         live == PSM_TRIP_GENERAL) begin
               supply_ok_lamp[i] <= 1'b0;
               current_ok_lamp[i] <= 1'b0;
            end else if (st == PSM_RUN && minimal_load[i]) begin
               supply_ok_lamp[i] <= 1'b0;
               current_ok_lamp[i] <= 1'b1;
            end else begin
               supply_ok_lamp[i] <= 1'b1;
               current_ok_lamp[i] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system level flags and alerts

   // combined indicators, all registered
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         system_power_good <= 1'b0;
         front_fault_lamp <= 1'b0;
         intrusion_alert <= 1'b0;
         fan_fail_alert <= 1'b0;
      end else begin
         // or of the same-cycle good terms
         system_power_good <= |next_good;
         // any supply fault lights front lamp
         front_fault_lamp <= |next_fault;
         intrusion_alert <= |intrusion_open;
         fan_fail_alert <= |fan_locked;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status bytes

   logic [7:0] supply_byte; // fault and presence per supply
   logic [7:0] fan_byte; // fail per fan

   // a fault bit and a presence bit per supply, one bit per fan
   always_comb begin
      supply_byte = 8'h00;
      fan_byte = 8'h00;
      supply_byte[`PSM_FAULT_POS +: NUM_SUPPLIES] = supply_fault;
      supply_byte[`PSM_PRESENT_POS +: NUM_SUPPLIES] = supply_present;
      fan_byte[`PSM_FAN_POS +: NUM_FANS] = fan_locked;
   end

   ////////////////////////////////////////////////////////////////////////
   // read-only i2c slave answering two addresses

   psm_i2c_e ist; // bus sequence state
   logic scl_d; // clock one cycle back
   logic sda_d; // data one cycle back
   logic [7:0] shreg; // address in, data out
   logic [3:0] bits; // bit counter
   logic sel_fan; // which byte was addressed
   logic scl_rise; // clock edges and bus conditions
   logic scl_fall;
   logic start_c;
   logic stop_c;

   assign scl_rise = scl_in & ~scl_d;
   assign scl_fall = ~scl_in & scl_d;
   assign start_c = scl_in & scl_d & sda_d & ~sda_in;
   assign stop_c = scl_in & scl_d & ~sda_d & sda_in;

   // pin history
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_in;
         sda_d <= sda_in;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ist <= PSM_I2C_IDLE;
         shreg <= 8'h00;
         bits <= 4'h0;
         sel_fan <= 1'b0;
         sda_out <= `PSM_SDA_RST;
         sda_oe_n <= 1'b1;
      end else if (start_c) begin
         // start or repeated start
         ist <= PSM_I2C_ADDR;
         bits <= 4'h0;
         sda_oe_n <= 1'b1;
      end else if (stop_c) begin
         ist <= PSM_I2C_IDLE;
         sda_oe_n <= 1'b1;
      end else begin
         case (ist)
            PSM_I2C_ADDR: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_in};
                  bits <= bits + 4'h1;
               end else if (scl_fall && bits == 4'h8) begin
                  // ack only a read to one of our addresses
                  if (shreg[0] && (shreg[7:1] == `PSM_ADDR_SUPPLY ||
                                   shreg[7:1] == `PSM_ADDR_FAN)) begin
                     sel_fan <= (shreg[7:1] == `PSM_ADDR_FAN);
                     sda_oe_n <= 1'b0;
                     ist <= PSM_I2C_ACK;
                  end else begin
                     ist <= PSM_I2C_IDLE;
                  end
               end
            end
            PSM_I2C_ACK: begin
               if (scl_fall) begin
                  // load the byte and put out its first bit
                  shreg <= sel_fan ? {fan_byte[6:0], 1'b0} :
                                     {supply_byte[6:0], 1'b0};
                  sda_oe_n <= sel_fan ? fan_byte[7] : supply_byte[7];
                  bits <= 4'h1;
                  ist <= PSM_I2C_SEND;
               end
            end
            PSM_I2C_SEND: begin
               if (scl_fall) begin
                  if (bits == 4'h8) begin
                     sda_oe_n <= 1'b1;
                     ist <= PSM_I2C_MACK;
                  end else begin
                     sda_oe_n <= shreg[7];
                     shreg <= {shreg[6:0], 1'b0};
                     bits <= bits + 4'h1;
                  end
               end
            end
            PSM_I2C_MACK: begin
               // master ack asks for the byte again
               if (scl_rise) begin
                  ist <= sda_in ? PSM_I2C_IDLE : PSM_I2C_ACK;
               end
            end
            default: begin
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

endmodule : psm_monitor
`default_nettype wire

// *** hdl/psm_pkg.sv ***
// types for the power supply status monitor
package psm_pkg;

   // life cycle of one supply
   typedef enum logic [2:0] {
      PSM_OFF,
      PSM_RAMP,
      PSM_RUN,
      PSM_DRAIN,
      PSM_TRIP
   } psm_supply_e;

   // class of the latched shutdown cause
   typedef enum logic [1:0] {
      PSM_TRIP_NONE,
      PSM_TRIP_HARD,
      PSM_TRIP_LIMIT,
      PSM_TRIP_GENERAL
   } psm_trip_e;

   // read-only i2c slave sequence
   typedef enum logic [2:0] {
      PSM_I2C_IDLE,
      PSM_I2C_ADDR,
      PSM_I2C_ACK,
      PSM_I2C_SEND,
      PSM_I2C_MACK
   } psm_i2c_e;

endpackage : psm_pkg

// *** testbench/psm_checker.sv ***
// port assertions for the supply status monitor
`timescale 1ns/100ps
`default_nettype none
module psm_checker #(
   parameter int NUM_SUPPLIES = 3,
   parameter int NUM_FANS = 3,
   parameter int NUM_CHANNELS = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // sensed inputs
   input wire logic [NUM_CHANNELS-1:0] channel_overload,
   input wire logic [NUM_SUPPLIES-1:0] supply_present,
   input wire logic [NUM_SUPPLIES-1:0] rail_5v1_ok,
   input wire logic [NUM_SUPPLIES-1:0] rails_in_reg,
   input wire logic [2:0] intrusion_open,
   input wire logic [NUM_FANS-1:0] fan_locked,
   // watched outputs
   input wire logic [NUM_SUPPLIES-1:0] supply_outputs_on,
   input wire logic [NUM_SUPPLIES-1:0] supply_fault,
   input wire logic [NUM_SUPPLIES-1:0] supply_output_good,
   input wire logic [NUM_SUPPLIES-1:0] current_ok_lamp,
   input wire logic system_power_good,
   input wire logic shared_supply_enable,
   input wire logic front_fault_lamp,
   input wire logic intrusion_alert,
   input wire logic fan_fail_alert,
   input wire logic sda_oe_n,
   input wire logic sda_out
);
   // cycles since reset release, saturating
   logic [1:0] up;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   // skip the internal reset release window
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst || up != 2'h3);
   ////////////////////////////////////////////////////////////////////
   chk_pg_or_merge: assert property (system_power_good == |supply_output_good)
      else $error("system power good not the or of flags");
   chk_front_lamp_any: assert property (|supply_fault |-> ##[0:1] front_fault_lamp)
      else $error("front fault lamp dark with a fault");
   chk_good_needs_on: assert property (!(|(supply_output_good & ~supply_outputs_on)))
      else $error("output good without outputs on");
   chk_good_lead_time: assert property ($fell(supply_output_good[0]) && !supply_fault[0]
      && supply_present[0] |-> supply_outputs_on[0] [*5])
      else $error("outputs dropped too soon after good");
   chk_good_rise_delay: assert property ($rose(supply_output_good[0]) |->
      $past(rail_5v1_ok[0], 20) && $past(rails_in_reg[0], 20))
      else $error("output good rose too early");
   chk_overload_cut: assert property (|channel_overload |=> !shared_supply_enable)
      else $error("enable kept during overload");
   chk_intrusion_or: assert property (intrusion_alert == |$past(intrusion_open))
      else $error("intrusion alert wrong");
   chk_fan_fail_or: assert property (fan_fail_alert == |$past(fan_locked))
      else $error("fan fail alert wrong");
   chk_fault_lamp_off: assert property (!(|(supply_fault & current_ok_lamp)))
      else $error("current lamp lit on a faulted supply");
   chk_sda_drive_low: assert property (!sda_oe_n |-> !sda_out)
      else $error("data pin enabled while driving high");
   // system good falls ahead of the outputs
   property sys_lead;
      $fell(system_power_good) && !(|supply_fault) |->
         (|supply_outputs_on) [*5];
   endproperty
   chk_sys_good_lead: assert property (sys_lead)
      else $error("outputs dropped too soon after system good");
   ////////////////////////////////////////////////////////////////////
   // main scenarios seen
   cov_power_good: cover property ($rose(system_power_good));
   cov_fault_lamp: cover property ($rose(front_fault_lamp));
   cov_i2c_ack: cover property ($fell(sda_oe_n));
endmodule : psm_checker
bind psm_monitor psm_checker #(
   .NUM_SUPPLIES(NUM_SUPPLIES),
   .NUM_FANS(NUM_FANS),
   .NUM_CHANNELS(NUM_CHANNELS)
) i_chk (.*);
`default_nettype wire

// *** testbench/psm_i2c_master.sv ***
// i2c master model reading the status slaves
`timescale 1ns/100ps
`default_nettype none
module psm_i2c_master (
   // clock and wired data line
   input wire logic mclk,
   input wire logic sda,
   // clock and data drive, 1 = released
   output logic scl,
   output logic sda_drv
);
   // bus idle, both lines released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // one third of a bit period
   task automatic ph();
      repeat (3) @(posedge mclk);
   endtask : ph
   // one bit slot, data changes only with clock low
   task automatic bt(input logic b, output logic r);
      ph();
      sda_drv <= b;
      ph();
      scl <= 1'b1;
      ph();
      r = sda;
      scl <= 1'b0;
   endtask : bt
   // single byte read: start, address, ack, data, nack, stop
   task automatic rd(input logic [6:0] a, output logic ack,
      output logic [7:0] d);
      logic [7:0] f;
      logic r;
      f = {a, 1'b1};
      ph();
      sda_drv <= 1'b0;
      ph();
      scl <= 1'b0;
      for (int i = 7; i >= 0; i--) bt(f[i], r);
      bt(1'b1, r);
      ack = ~r;
      for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
      bt(1'b1, r);
      ph();
      sda_drv <= 1'b0;
      ph();
      scl <= 1'b1;
      ph();
      sda_drv <= 1'b1;
      ph();
   endtask : rd
endmodule : psm_i2c_master
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench of the supply status monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic mclk, nrst, enable_request, scl_in, sda_drv;
   logic [3:0] channel_overload;
   logic [2:0] supply_present, over_voltage, supply_fan_fail, over_temp;
   logic [2:0] neg_short, current_limit, fet_fault, share_fault;
   logic [2:0] rail_5v1_ok, rails_in_reg, rail_drop_warn, minimal_load;
   logic [2:0] intrusion_open, fan_locked, supply_outputs_on, supply_fault;
   logic [2:0] supply_output_good, supply_ok_lamp, current_ok_lamp;
   logic system_power_good, shared_supply_enable, front_fault_lamp;
   logic intrusion_alert, fan_fail_alert, sda_out, sda_oe_n;
   logic [7:0] seed;
   int mismatches, checked;
   wire logic sda_in;
   // wired-and data line with pull-up
   assign sda_in = sda_drv & (sda_oe_n | sda_out);
   psm_monitor #(.PG_DELAY_CYC(20), .PG_LEAD_CYC(5)) i_dut (.*);
   psm_i2c_master i_mst (.mclk(mclk), .sda(sda_in), .scl(scl_in),
      .sda_drv(sda_drv));
   ////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // verdict and end of run
   task automatic report_and_stop();
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   // watchdog
   initial begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      report_and_stop();
   end
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
   endtask : tk
   // lfsr stimulus source
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // status of one supply plus system outputs
   function automatic logic [7:0] st(input int s);
      return {supply_outputs_on[s], supply_fault[s], supply_output_good[s],
         supply_ok_lamp[s], current_ok_lamp[s], system_power_good,
         shared_supply_enable, front_fault_lamp};
   endfunction : st
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: status %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp_rd(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask : cmp_rd
   // i2c read of one status byte, ack in the top bit
   task automatic rd(input logic [6:0] a, input logic [8:0] e);
      logic ack;
      logic [7:0] d;
      i_mst.rd(a, ack, d);
      cmp_rd({ack, d}, e);
   endtask : rd
   // raise or clear one sense input of one supply
   task automatic flt(input int k, input int s, input logic v);
      case (k)
         0: over_voltage[s] <= v;
         1: supply_fan_fail[s] <= v;
         2: over_temp[s] <= v;
         3: neg_short[s] <= v;
         4: fet_fault[s] <= v;
         5: current_limit[s] <= v;
         default: share_fault[s] <= v;
      endcase
   endtask : flt
   ////////////////////////////////////////////////////////////////////
   initial begin
      mismatches = 0;
      checked = 0;
      seed = 8'h16;
      {nrst, enable_request, channel_overload} = 6'h00;
      {over_voltage, supply_fan_fail, over_temp, neg_short} = 12'h000;
      {current_limit, fet_fault, share_fault, rail_drop_warn} = 12'h000;
      {minimal_load, intrusion_open, fan_locked} = 9'h000;
      // 5.1v rail still below its level at power up
      {supply_present, rail_5v1_ok, rails_in_reg} = 9'h1c7;
      tk(3);
      cmp(st(0), 8'h00);
      cmp({7'h0, sda_oe_n}, 8'h01);
      nrst <= 1'b1;
      tk(4);
      enable_request <= 1'b1;
      tk(12);
      cmp(st(0), 8'h9a);
      // 5.1v reaches its level, good delay starts
      rail_5v1_ok <= 3'h7;
      tk(30);
      for (int s = 0; s < 3; s++) cmp(st(s), 8'hbe);
      minimal_load <= 3'h2;
      tk(3);
      cmp(st(1), 8'hae);
      minimal_load <= 3'h0;
      for (int k = 0; k < 7; k++) begin
         flt(k, k % 3, 1'b1);
         tk(4);
         cmp(st(k % 3) & (k == 4 ? 8'h7f : 8'hff), k == 5 ? 8'h57 : 8'h47);
         if (k == 6) rd(7'h44, 9'h139);
         if (k == 6) rd(7'h45, 9'h0ff);
         flt(k, k % 3, 1'b0);
         supply_present[k % 3] <= 1'b0;
         tk(4);
         cmp(st(k % 3), 8'h06);
         if (k == 6) rd(7'h44, 9'h130);
         supply_present[k % 3] <= 1'b1;
         tk(40);
         cmp(st(k % 3), 8'hbe);
      end
      rail_drop_warn <= 3'h4;
      tk(3);
      cmp({5'h0, supply_outputs_on[2], supply_output_good[2],
         system_power_good}, 8'h05);
      rail_drop_warn <= 3'h0;
      tk(40);
      seed = lfsr(seed);
      channel_overload <= seed[3:0] | 4'h1;
      tk(12);
      channel_overload <= 4'h0;
      tk(3);
      cmp(st(0), 8'h18);
      enable_request <= 1'b0;
      tk(3);
      enable_request <= 1'b1;
      tk(40);
      cmp(st(2), 8'hbe);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         intrusion_open <= seed[2:0];
         fan_locked <= seed[5:3];
         tk(3);
         cmp({6'h0, intrusion_alert, fan_fail_alert},
            {6'h0, |seed[2:0], |seed[5:3]});
         rd(7'h40, {1'b1, 5'h00, seed[5:3]});
      end
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
